//--- logic/pd_rst_regs.svh
// Register offsets, field positions, reset values and counts of the PD reset block
`ifndef PD_RST_REGS_SVH
`define PD_RST_REGS_SVH
// ----------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------
`define OFS_CTRL        8'h00
`define OFS_CMD         8'h04
`define OFS_COUNT       8'h08
`define OFS_FLAGS       8'h0c
// ----------------------------------------------------------
// Control fields and reset value
// ----------------------------------------------------------
`define CTRL_RP         0
`define CTRL_VCONN_SUP  1
`define CTRL_CAPS_EN    2
`define CTRL_BUSY_ONE   3
`define CTRL_RST        4'h1
// ----------------------------------------------------------
// Command fields (write one to act)
// ----------------------------------------------------------
`define CMD_CABLE       0
`define CMD_OWN_AMS     1
`define CMD_AMS_DONE    2
// ----------------------------------------------------------
// Counter limits
// ----------------------------------------------------------
`define N_BUSY          3'h5
`define N_BUSY_MODE     3'h1
`define N_CAPS          6'h32
`define N_DISC          5'h14
`define N_HARD          2'h2
`define N_MSGID         3'h7
`define N_RETRY         2'h2
// ----------------------------------------------------------
// Timing
// ----------------------------------------------------------
`define T_SOFT_RESET_MS 15
`define CLK_KHZ         100000
`endif

//--- logic/pd_rst_pkg.sv
// Types of the PD reset and counter block
package pd_rst_pkg;
  // Cable Reset preparation, Gray along idle-vconn-send
  typedef enum logic [1:0] {
    CR_IDLE  = 2'b00,
    CR_VCONN = 2'b01,
    CR_SEND  = 2'b11
  } cab_state_t;

  // Event pulses from protocol layer and policy engine
  typedef struct packed {
    logic disc_sent;      // Discover Identity sent to plug
    logic disc_goodcrc;   // GoodCRC to Discover Identity
    logic drs_done;       // Data Role Swap completed
    logic busy_sent;      // Responder Busy reply sent
    logic nonbusy_sent;   // Other reply to structured VDM
    logic msg_acked;      // GoodCRC with matching number
    logic crc_timeout;    // CRC receive timer expired
    logic sr_rx;          // Soft_Reset message received
    logic sr_sent;        // Soft_Reset transmission done
    logic sr_fail;        // Soft Reset exchange failed
    logic hr_rx;          // Hard Reset signalling seen
    logic hr_sent;        // Hard Reset signalling sent
    logic hr_noresp;      // No response after Hard Reset
    logic caps_sent;      // Source_Capabilities sent
    logic prot_err;       // Unexpected message in sequence
    logic vswap_done;     // VCONN Swap finished, we supply
  } evt_t;

  // Sequence context levels
  typedef struct packed {
    logic first_pending;  // First message not yet acked
    logic interruptible;  // Current sequence interruptible
    logic active;         // A sequence is under way
    logic v_transition;   // Supply voltage transitioning
    logic sop_is_sop;     // Exchange uses SOP packets
  } ams_t;

  // Core state held in flip-flops
  typedef struct packed {
    logic [2:0]  msg_id;
    logic [1:0]  retry;
    logic [1:0]  hr_cnt;
    logic [4:0]  disc_cnt;
    logic [2:0]  busy_cnt;
    logic [5:0]  caps_cnt;
    logic        dead;
    logic        dfp;
    logic        vconn_en;
    logic        rp_ok;
    logic        sr_pend;
    logic [20:0] sr_tmr;
    cab_state_t  cab;
    logic        soft_req;
    logic        hard_req;
    logic        cable_req;
    logic        vswap_req;
    logic        to_ready;
    logic        modes_exit;
    logic        sink_may;
  } core_t;
endpackage : pd_rst_pkg

//--- logic/pd_reset_counters.sv
// PD protocol counters, reset policy and collision avoidance with AXI4-Lite registers
`timescale 1ns/1ps
`include "pd_rst_regs.svh"
module pd_reset_counters
  import pd_rst_pkg::*;
#(
  parameter logic [2:0]  BUSY_LIMIT = `N_BUSY,
  parameter logic [5:0]  CAPS_LIMIT = `N_CAPS,
  parameter logic [4:0]  DISC_LIMIT = `N_DISC,
  parameter logic [1:0]  HARD_LIMIT = `N_HARD,
  parameter logic [1:0]  RTRY_LIMIT = `N_RETRY,
  parameter logic [20:0] SR_CYCLES  = 21'(`T_SOFT_RESET_MS * `CLK_KHZ)
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  input  wire logic [7:0]  s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  // Protocol side
  input  wire evt_t        evt,
  input  wire ams_t        ams,
  input  wire logic        connected,
  input  wire logic        explicit_contract,
  input  wire logic        partner_vconn,
  input  wire logic        rp_seen_ok,
  output logic [2:0]       msg_id,
  output logic             disc_allow,
  output logic             busy_allow,
  output logic             caps_allow,
  output logic             partner_dead,
  output logic             data_dfp,
  output logic             vconn_en,
  output logic             rp_sink_tx_ok,
  output logic             sink_may_start,
  output logic             soft_reset_req,
  output logic             hard_reset_req,
  output logic             cable_reset_req,
  output logic             vconn_swap_req,
  output logic             pe_to_ready,
  output logic             modes_exit
);
  // ----------------------------------------------------------
  // Bus state
  // ----------------------------------------------------------
  logic        aw_got_reg, aw_got_next;   // Write address held
  logic        w_got_reg,  w_got_next;    // Write data held
  logic [7:0]  waddr_reg,  waddr_next;    // Held write address
  logic [31:0] wdata_reg,  wdata_next;    // Held write data
  logic [3:0]  wstrb_reg,  wstrb_next;    // Held byte enables
  logic        awr_reg,    awr_next;      // Address ready
  logic        wr_reg,     wr_next;       // Data ready
  logic        bv_reg,     bv_next;       // Write answer valid
  logic [1:0]  br_reg,     br_next;       // Write answer code
  logic        arr_reg,    arr_next;      // Read address ready
  logic        rv_reg,     rv_next;       // Read answer valid
  logic [31:0] rd_reg,     rd_next;       // Read data
  logic [1:0]  rr_reg,     rr_next;       // Read answer code
  logic [3:0]  ctrl_reg,   ctrl_next;     // Control register
  logic        wr_fire;                   // Write performed now
  logic [2:0]  cmd_pulse;                 // Command strobes

  // ----------------------------------------------------------
  // Core state
  // ----------------------------------------------------------
  core_t st_reg, st_next;                 // All policy state
  logic [2:0] busy_lim;                   // Active busy limit
  logic [2:0] ok_reg, ok_next;            // Limit flags: caps, busy, disc

  // Reset value of the core
  localparam core_t CORE_RST = '{
    dfp: 1'b1, vconn_en: 1'b0, rp_ok: 1'b1, cab: CR_IDLE,
    default: '0};

  // ----------------------------------------------------------
  // Register bus, next values
  // ----------------------------------------------------------
  always_comb begin
    aw_got_next = aw_got_reg;
    w_got_next  = w_got_reg;
    waddr_next  = waddr_reg;
    wdata_next  = wdata_reg;
    wstrb_next  = wstrb_reg;
    bv_next     = bv_reg;
    br_next     = br_reg;
    rv_next     = rv_reg;
    rd_next     = rd_reg;
    rr_next     = rr_reg;
    ctrl_next   = ctrl_reg;
    wr_fire     = 1'b0;
    cmd_pulse   = 3'h0;
    // Capture address and data in either order
    if (s_awvalid && awr_reg) begin
      aw_got_next = 1'b1;
      waddr_next  = s_awaddr;
    end
    if (s_wvalid && wr_reg) begin
      w_got_next = 1'b1;
      wdata_next = s_wdata;
      wstrb_next = s_wstrb;
    end
    // Both halves present: perform and answer
    if (aw_got_reg && w_got_reg && !bv_reg) begin
      wr_fire     = 1'b1;
      aw_got_next = 1'b0;
      w_got_next  = 1'b0;
      bv_next     = 1'b1;
      br_next     = 2'h0;
      case (waddr_reg)
        `OFS_CTRL: begin
          if (wstrb_reg[0]) begin
            ctrl_next = wdata_reg[3:0];
          end
        end
        `OFS_CMD: begin
          if (wstrb_reg[0]) begin
            cmd_pulse = wdata_reg[2:0];
          end
        end
        `OFS_COUNT, `OFS_FLAGS: br_next = 2'h0;   // Read-only, write ignored
        default: br_next = 2'h2;                  // Unmapped address
      endcase
    end
    if (bv_reg && s_bready) bv_next = 1'b0;
    // Read: one cycle from address to data
    if (s_arvalid && arr_reg) begin
      rv_next = 1'b1;
      rr_next = 2'h0;
      case (s_araddr)
        `OFS_CTRL:  rd_next = {28'h0, ctrl_reg};
        `OFS_CMD:   rd_next = 32'h0;
        `OFS_COUNT: rd_next = {11'h0, st_reg.caps_cnt, st_reg.busy_cnt,
                               st_reg.disc_cnt, st_reg.hr_cnt,
                               st_reg.retry, st_reg.msg_id};
        `OFS_FLAGS: rd_next = {24'h0, st_reg.sink_may, st_reg.cab,
                               st_reg.rp_ok, st_reg.vconn_en,
                               st_reg.dfp, st_reg.dead, st_reg.sr_pend};
        default: begin
          rd_next = 32'h0;
          rr_next = 2'h2;           // Unmapped address
        end
      endcase
    end else if (rv_reg && s_rready) begin
      rv_next = 1'b0;
    end
    awr_next = !aw_got_next && !bv_next;
    wr_next  = !w_got_next && !bv_next;
    arr_next = !rv_next;
  end

  // Register bus, flip-flops
  always_ff @(posedge clk) begin
    if (!nrst) begin
      aw_got_reg <= 1'b0;
      w_got_reg  <= 1'b0;
      waddr_reg  <= 8'h00;
      wdata_reg  <= 32'h0;
      wstrb_reg  <= 4'h0;
      awr_reg    <= 1'b0;
      wr_reg     <= 1'b0;
      bv_reg     <= 1'b0;
      br_reg     <= 2'h0;
      arr_reg    <= 1'b0;
      rv_reg     <= 1'b0;
      rd_reg     <= 32'h0;
      rr_reg     <= 2'h0;
      ctrl_reg   <= `CTRL_RST;
    end else begin
      aw_got_reg <= aw_got_next;
      w_got_reg  <= w_got_next;
      waddr_reg  <= waddr_next;
      wdata_reg  <= wdata_next;
      wstrb_reg  <= wstrb_next;
      awr_reg    <= awr_next;
      wr_reg     <= wr_next;
      bv_reg     <= bv_next;
      br_reg     <= br_next;
      arr_reg    <= arr_next;
      rv_reg     <= rv_next;
      rd_reg     <= rd_next;
      rr_reg     <= rr_next;
      ctrl_reg   <= ctrl_next;
    end
  end

  // ----------------------------------------------------------
  // Policy core, next values
  // ----------------------------------------------------------
  always_comb begin
    logic proto_clr;                      // Protocol layer reset
    logic hard_evt;                       // Hard Reset now
    logic sr_bad;                         // Soft Reset failed
    logic cab_ask;                        // Cable Reset wanted
    proto_clr = 1'b0;
    hard_evt  = evt.hr_rx || evt.hr_sent;
    sr_bad    = evt.sr_fail;
    cab_ask   = cmd_pulse[`CMD_CABLE];
    busy_lim  = ctrl_reg[`CTRL_BUSY_ONE] ? `N_BUSY_MODE : BUSY_LIMIT;
    st_next   = st_reg;
    // Pulses last one cycle
    st_next.soft_req   = 1'b0;
    st_next.hard_req   = 1'b0;
    st_next.cable_req  = 1'b0;
    st_next.vswap_req  = 1'b0;
    st_next.to_ready   = 1'b0;
    st_next.modes_exit = 1'b0;
    // Discover Identity count, cleared by swap or reply
    if (evt.drs_done || evt.disc_goodcrc) begin
      st_next.disc_cnt = 5'h0;
    end else if (evt.disc_sent && st_reg.disc_cnt < DISC_LIMIT) begin
      st_next.disc_cnt = st_reg.disc_cnt + 5'h1;
    end
    if (evt.drs_done) st_next.dfp = !st_reg.dfp;
    // Busy reply count
    if (evt.nonbusy_sent) begin
      st_next.busy_cnt = 3'h0;
    end else if (evt.busy_sent && st_reg.busy_cnt < busy_lim) begin
      st_next.busy_cnt = st_reg.busy_cnt + 3'h1;
    end
    // Capabilities count
    if (evt.caps_sent && st_reg.caps_cnt < CAPS_LIMIT) begin
      st_next.caps_cnt = st_reg.caps_cnt + 6'h1;
    end
    // Message number and retries
    if (evt.msg_acked) begin
      st_next.retry  = 2'h0;
      st_next.msg_id = (st_reg.msg_id == `N_MSGID) ? 3'h0 :
                       st_reg.msg_id + 3'h1;
    end else if (evt.crc_timeout) begin
      if (st_reg.retry == RTRY_LIMIT) begin
        st_next.retry = 2'h0;
        // Retries spent: Source starts a Soft Reset
        if (connected && ctrl_reg[`CTRL_RP] && !st_reg.sr_pend) begin
          st_next.soft_req = 1'b1;
          st_next.sr_pend  = 1'b1;
          st_next.sr_tmr   = SR_CYCLES;
          proto_clr        = 1'b1;
        end
      end else begin
        st_next.retry = st_reg.retry + 2'h1;
      end
    end
    // Soft_Reset must leave within its deadline
    if (st_reg.sr_pend) begin
      if (evt.sr_sent) begin
        st_next.sr_pend = 1'b0;
      end else if (st_reg.sr_tmr <= 21'h1) begin
        st_next.sr_pend = 1'b0;
        sr_bad          = 1'b1;
      end else begin
        st_next.sr_tmr = st_reg.sr_tmr - 21'h1;
      end
    end
    // Protocol Error policy
    if (evt.prot_err && ams.active) begin
      if (ams.first_pending) begin
        st_next.to_ready = 1'b1;
      end else if (ams.interruptible) begin
        st_next.to_ready = 1'b1;
      end else if (ams.v_transition) begin
        st_next.hard_req = 1'b1;
      end else begin
        st_next.soft_req = 1'b1;
        proto_clr        = 1'b1;
      end
    end
    // Failed Soft Reset escalates by packet type
    if (sr_bad) begin
      if (ams.sop_is_sop) begin
        st_next.hard_req = 1'b1;
      end else begin
        cab_ask = 1'b1;
      end
    end
    // Received Soft_Reset: clear before Accept goes out
    if (evt.sr_rx) proto_clr = 1'b1;
    // Hard Reset without answer: retry or give up
    if (evt.hr_noresp) begin
      if (st_reg.hr_cnt < HARD_LIMIT) begin
        st_next.hr_cnt   = st_reg.hr_cnt + 2'h1;
        st_next.hard_req = 1'b1;
      end else begin
        st_next.dead = 1'b1;
      end
    end
    // Hard Reset reverts port to termination defaults
    if (hard_evt) begin
      proto_clr          = 1'b1;
      st_next.sr_pend    = 1'b0;
      st_next.caps_cnt   = 6'h0;
      st_next.dfp        = ctrl_reg[`CTRL_RP];
      st_next.vconn_en   = ctrl_reg[`CTRL_RP] &&
                           ctrl_reg[`CTRL_VCONN_SUP];
      st_next.modes_exit = 1'b1;
      st_next.rp_ok      = 1'b1;
      st_next.cab        = CR_IDLE;
    end
    // Source collision avoidance on Rp
    if (cmd_pulse[`CMD_OWN_AMS]) begin
      st_next.rp_ok = 1'b0;
    end else if (cmd_pulse[`CMD_AMS_DONE]) begin
      st_next.rp_ok = 1'b1;
    end
    // Sink may only start when the Source shows SinkTxOk
    st_next.sink_may = !ctrl_reg[`CTRL_RP] && rp_seen_ok;
    // Cable Reset preparation
    case (st_reg.cab)
      CR_IDLE: begin
        if (cab_ask && st_reg.dfp && explicit_contract && !hard_evt) begin
          if (st_reg.vconn_en) begin
            st_next.cab = CR_SEND;
          end else if (partner_vconn) begin
            st_next.vswap_req = 1'b1;
            st_next.cab       = CR_VCONN;
          end else begin
            st_next.vconn_en = 1'b1;
            st_next.cab      = CR_SEND;
          end
        end
      end
      CR_VCONN: begin
        if (evt.vswap_done && !hard_evt) begin
          st_next.vconn_en = 1'b1;
          st_next.cab      = CR_SEND;
        end
      end
      CR_SEND: begin
        if (!hard_evt) begin
          st_next.cable_req  = 1'b1;
          st_next.modes_exit = 1'b1;
          st_next.cab        = CR_IDLE;
          proto_clr          = 1'b1;
        end
      end
      default: st_next.cab = CR_IDLE;
    endcase
    // Protocol layer reset wins over counting
    if (proto_clr) begin
      st_next.msg_id = 3'h0;
      st_next.retry  = 2'h0;
    end
    ok_next[0] = st_next.disc_cnt < DISC_LIMIT;
    ok_next[1] = st_next.busy_cnt < (ctrl_next[`CTRL_BUSY_ONE] ? `N_BUSY_MODE : BUSY_LIMIT);
    ok_next[2] = !ctrl_next[`CTRL_CAPS_EN] || st_next.caps_cnt < CAPS_LIMIT;
  end

  // Policy core, flip-flops
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_reg <= CORE_RST;
      ok_reg <= 3'h7;
    end else begin
      st_reg <= st_next;
      ok_reg <= ok_next;
    end
  end

  // ----------------------------------------------------------
  // Outputs, each straight from a flip-flop
  // ----------------------------------------------------------
  assign s_awready       = awr_reg;
  assign s_wready        = wr_reg;
  assign s_bvalid        = bv_reg;
  assign s_bresp         = br_reg;
  assign s_arready       = arr_reg;
  assign s_rvalid        = rv_reg;
  assign s_rdata         = rd_reg;
  assign s_rresp         = rr_reg;
  assign msg_id          = st_reg.msg_id;
  assign partner_dead    = st_reg.dead;
  assign data_dfp        = st_reg.dfp;
  assign vconn_en        = st_reg.vconn_en;
  assign rp_sink_tx_ok   = st_reg.rp_ok;
  assign sink_may_start  = st_reg.sink_may;
  assign soft_reset_req  = st_reg.soft_req;
  assign hard_reset_req  = st_reg.hard_req;
  assign cable_reset_req = st_reg.cable_req;
  assign vconn_swap_req  = st_reg.vswap_req;
  assign pe_to_ready     = st_reg.to_ready;
  assign modes_exit      = st_reg.modes_exit;
  assign disc_allow      = ok_reg[0];
  assign busy_allow      = ok_reg[1];
  assign caps_allow      = ok_reg[2];
endmodule : pd_reset_counters

//--- verif/pd_partner.sv
// Port partner model driving protocol event pulses
`timescale 1ns/1ps
module pd_partner
  import pd_rst_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       fire,
  input  wire logic [3:0] code,
  input  wire logic       vconn_swap_req,
  output evt_t            evt
);
  logic [2:0] sw_reg;  // Swap progress shift
  logic [2:0] sw_next; // Next swap progress
  // ----------------------------------------
  // Swap answer
  // ----------------------------------------
  always_comb begin
    sw_next = {sw_reg[1:0], vconn_swap_req}; // Partner hands VCONN over
  end
  always_ff @(posedge clk) begin
    sw_reg <= nrst ? sw_next : 3'h0;
  end
  // Fired code drives any one event bit, hr_rx included
  always_comb begin
    evt = fire ? evt_t'(16'h0001 << code) : evt_t'(16'h0000);
    evt.vswap_done = evt.vswap_done | sw_reg[2]; // Swap finished
  end
endmodule : pd_partner

//--- verif/pd_rst_checker.sv
// Port assertions of the PD reset block
`timescale 1ns/1ps
module pd_rst_checker
  import pd_rst_pkg::*;
(
  input wire logic       clk,
  input wire logic       nrst,
  input wire evt_t       evt,
  input wire ams_t       ams,
  input wire logic       rp_seen_ok,
  input wire logic [2:0] msg_id,
  input wire logic       disc_allow,
  input wire logic       busy_allow,
  input wire logic       partner_dead,
  input wire logic       data_dfp,
  input wire logic       vconn_en,
  input wire logic       rp_sink_tx_ok,
  input wire logic       sink_may_start,
  input wire logic       soft_reset_req,
  input wire logic       hard_reset_req,
  input wire logic       cable_reset_req,
  input wire logic       pe_to_ready,
  input wire logic       modes_exit
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // ----------------------------------------
  // Error sequences
  // ----------------------------------------
  sequence s_err; evt.prot_err && ams.active; endsequence
  sequence s_ok; s_err ##0 (ams.first_pending || ams.interruptible); endsequence
  sequence s_ni; s_err ##0 !ams.first_pending && !ams.interruptible; endsequence
  property p_wrap; evt == evt_t'(16'h0400) |=> msg_id == 3'($past(msg_id) + 3'h1); endproperty
  property p_sr; evt.sr_rx |=> msg_id == 3'h0; endproperty
  property p_hr; evt.hr_rx |=> modes_exit && msg_id == 3'h0 && rp_sink_tx_ok; endproperty
  property p_disc; evt.drs_done |=> disc_allow; endproperty
  property p_busy; evt.nonbusy_sent |=> busy_allow; endproperty
  property p_dead; partner_dead |=> partner_dead; endproperty
  property p_rdy; s_ok |=> pe_to_ready && !soft_reset_req; endproperty
  property p_soft; s_ni ##0 !ams.v_transition |=> soft_reset_req; endproperty
  property p_vtr; s_ni ##0 ams.v_transition |=> hard_reset_req; endproperty
  property p_esc; evt.sr_fail && ams.sop_is_sop |=> hard_reset_req; endproperty
  property p_cdfp; cable_reset_req |-> data_dfp; endproperty
  property p_cvc; cable_reset_req |-> vconn_en; endproperty
  property p_sink; sink_may_start |-> $past(rp_seen_ok); endproperty
  a_wrap: assert property (p_wrap) else $error("message number step wrong");
  a_sr: assert property (p_sr) else $error("number kept on reset");
  a_hr: assert property (p_hr) else $error("hard reset effects missing");
  a_disc: assert property (p_disc) else $error("discover count kept");
  a_busy: assert property (p_busy) else $error("busy count kept");
  a_dead: assert property (p_dead) else $error("dead flag dropped");
  a_rdy: assert property (p_rdy) else $error("no return to ready");
  a_soft: assert property (p_soft) else $error("no soft reset");
  a_vtr: assert property (p_vtr) else $error("no hard reset");
  a_esc: assert property (p_esc) else $error("no escalation");
  a_cdfp: assert property (p_cdfp) else $error("cable reset as UFP");
  a_cvc: assert property (p_cvc) else $error("cable reset without VCONN");
  a_sink: assert property (p_sink) else $error("sink start not gated");
endmodule : pd_rst_checker
bind pd_reset_counters pd_rst_checker u_chk (.clk, .nrst, .evt, .ams, .rp_seen_ok,
  .msg_id, .disc_allow, .busy_allow, .partner_dead, .data_dfp, .vconn_en, .rp_sink_tx_ok,
  .sink_may_start, .soft_reset_req, .hard_reset_req, .cable_reset_req, .pe_to_ready,
  .modes_exit);

//--- verif/tb_top.sv
// Register and event tests of the PD reset block
`timescale 1ns/1ps
`include "pd_rst_regs.svh"
`define CHK(n, e, v) begin tests_run++; if ((v) !== (e)) begin errors++; \
  $display("unexpected %s exp %h got %h", n, e, v); end end
module tb_top;
  import pd_rst_pkg::*;
  logic clk = 0, nrst = 0, fire = 0;
  logic [7:0] s_awaddr = 0, s_araddr = 0;
  logic [31:0] s_wdata = 0, s_rdata, rdv;
  logic [3:0] s_wstrb = 4'hf, code = 0;
  logic s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0, s_rready = 0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0] s_bresp, s_rresp, rsp;
  evt_t evt;
  ams_t ams = ams_t'(5'h01);
  logic connected = 0, explicit_contract = 0, partner_vconn = 0, rp_seen_ok = 0;
  logic [2:0] msg_id;
  logic disc_allow, busy_allow, caps_allow, partner_dead, data_dfp, vconn_en;
  logic rp_sink_tx_ok, sink_may_start, soft_reset_req, hard_reset_req;
  logic cable_reset_req, vconn_swap_req, pe_to_ready, modes_exit;
  int errors = 0, tests_run = 0, n_soft = 0, n_hard = 0, n_cab = 0, n_rdy = 0, n_mx = 0;
  logic [4:0] pe [4] = '{5'h14, 5'h0c, 5'h06, 5'h04}; // Error contexts
  always #5 clk = ~clk;
  pd_reset_counters #(.SR_CYCLES(21'd50)) uut (.*);
  pd_partner far (.*);
  // Pulse counters
  always @(posedge clk) if (nrst) begin
    n_soft += soft_reset_req; n_hard += hard_reset_req; n_cab += cable_reset_req;
    n_rdy += pe_to_ready; n_mx += modes_exit;
  end
  task automatic ev(input int b, input int n);
    repeat (n) begin
      @(posedge clk) begin fire <= 1'b1; code <= 4'(b); end
      @(posedge clk) fire <= 1'b0;
      @(posedge clk);                    // Pulse outputs counted one edge later
      #1;
    end
  endtask : ev
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) begin s_awaddr <= a; s_wdata <= d; s_awvalid <= 1; s_wvalid <= 1; end
    s_bready <= 1;
    do begin
      @(posedge clk) begin if (s_awready) s_awvalid <= 0; if (s_wready) s_wvalid <= 0; end
    end while (!s_bvalid);
    rsp = s_bresp;
    s_bready <= 0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk) begin s_araddr <= a; s_arvalid <= 1; s_rready <= 1; end
    do begin
      @(posedge clk) if (s_arready) s_arvalid <= 0;
    end while (!s_rvalid);
    rdv = s_rdata;
    rsp = s_rresp;
    s_rready <= 0;
    #1;
  endtask : rd
  task automatic close_out();
    $display("mismatches %0d of %0d checks", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out
  initial begin #100000; errors++; close_out(); end
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1;
    rd(`OFS_CTRL); `CHK("ctrl", 32'h1, rdv)
    rd(`OFS_FLAGS); `CHK("flags", 32'h14, rdv)
    rd(8'h10); `CHK("resp", 2'b10, rsp)
    wr(8'h10, 32'h0); `CHK("bresp", 2'b10, rsp)
    ev(10, 7); `CHK("msg_id", 3'h7, msg_id)
    ev(10, 1); `CHK("msg_id", 3'h0, msg_id)
    ev(10, 3); ev(8, 1); `CHK("msg_id", 3'h0, msg_id)
    ev(15, 19); `CHK("disc", 1'b1, disc_allow)
    ev(15, 1); `CHK("disc", 1'b0, disc_allow)
    ev(13, 1); `CHK("disc", 1'b1, disc_allow)
    ev(5, 1); `CHK("dfp", 1'b1, data_dfp)
    `CHK("modes", 1, n_mx)
    ev(12, 5); `CHK("busy", 1'b0, busy_allow)
    ev(11, 1); `CHK("busy", 1'b1, busy_allow)
    wr(`OFS_CTRL, 32'hd); ev(12, 1); `CHK("busy", 1'b0, busy_allow)
    ev(2, 49); `CHK("caps", 1'b1, caps_allow)
    ev(2, 1); `CHK("caps", 1'b0, caps_allow)
    ev(3, 2); `CHK("hard", 2, n_hard)
    ev(3, 1); `CHK("dead", 1'b1, partner_dead)
    @(posedge clk) connected <= 1;
    ev(10, 2); ev(9, 3); `CHK("soft", 1, n_soft)
    `CHK("msg_id", 3'h0, msg_id)
    ev(7, 1);
    for (int i = 0; i < 4; i++) begin @(posedge clk) ams <= ams_t'(pe[i]); ev(1, 1); end
    ev(7, 1); `CHK("ready", 2, n_rdy)
    `CHK("soft", 2, n_soft)
    @(posedge clk) ams <= ams_t'(5'h01);
    ev(6, 1); `CHK("hard", 4, n_hard)
    ev(9, 3); repeat (60) @(posedge clk);
    #1; `CHK("hard", 5, n_hard)
    wr(`OFS_CMD, 32'h1); ev(0, 5); `CHK("cable", 0, n_cab)
    @(posedge clk) begin explicit_contract <= 1; partner_vconn <= 1; end
    wr(`OFS_CMD, 32'h1);
    for (int t = 0; t < 50 && n_cab == 0; t++) @(posedge clk);
    #1; `CHK("cable", 1, n_cab)
    `CHK("vconn", 1'b1, vconn_en)
    `CHK("modes", 2, n_mx)
    @(posedge clk) ams <= ams_t'(5'h00);
    ev(6, 1); @(posedge clk);
    #1; `CHK("cable", 2, n_cab)
    wr(`OFS_CMD, 32'h2); `CHK("rp", 1'b0, rp_sink_tx_ok)
    wr(`OFS_CMD, 32'h4); `CHK("rp", 1'b1, rp_sink_tx_ok)
    wr(`OFS_CTRL, 32'h0);
    @(posedge clk) rp_seen_ok <= 1;
    ev(0, 2); `CHK("sink", 1'b1, sink_may_start)
    close_out();
  end
endmodule : tb_top
